/* File: design/fcd_top.v */
// fet and current adc self-test register block on ahb-lite
// assumes single-word transfers; converters and fet detectors
// sit outside; only the detectors are synchronised here
//
// How it works
// - target field 00 charge on, 01 discharge on, 10 charge off, 11 discharge off
// - enable bit written one starts checking, zero stops it
// - pass bits 3..0: charge on/off, discharge on/off
// - diagnostic mode feeds adc from fixed 100 mV reference
// - fast adc finishes running slot before entering diagnostic
// - slow adc finishes running slot before entering diagnostic
// - fast done flag set per conversion, cleared by writing one
// - fast capture bit copies value to result, self-clears
// - slow done flag set per conversion, cleared by writing one
// - slow capture updates result, drops slow irq, self-clears
// - fast irq rises on completion, falls on fast capture
// - second completion after enable carries first diagnostic data
// - after disable real data starts at second completion
// - slow result is signed, 360 mV over 2^16 per step
// - adc enable bits 0 fast, 1 slow, both off at reset
// - fet check runs only in active mode
// - pass bits read zero while check is disabled
`timescale 1ns/100ps
`include "fcd_defs.vh"
module fcd_top (
   // ahb clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [`FCD_AW-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg [1:0] hresp,
   // fet driver detectors, asynchronous
   input wire charge_gate_high,
   input wire discharge_gate_high,
   // converters, on hclk
   input wire fast_conv_done,
   input wire [15:0] fast_conv_value,
   input wire slow_conv_done,
   input wire [15:0] slow_conv_value,
   // controls to the analog side
   output reg fast_adc_on,
   output reg slow_adc_on,
   output reg fast_input_to_reference,
   output reg slow_input_to_reference,
   output reg charge_switch_control,
   output reg discharge_switch_control,
   // completion interrupts
   output reg fast_done_irq,
   output reg slow_done_irq
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg active_state;
   reg fet_check_enable;
   reg [1:0] fet_check_target;
   reg fast_adc_selftest_enable;
   reg slow_adc_selftest_enable;
   reg fast_result_capture;
   reg slow_result_capture;
   reg wr_pend;
   reg [`FCD_AW-3:0] wr_idx;
   wire [3:0] pass_flags;
   wire fast_diag_mode, slow_diag_mode;
   wire fast_conversion_done, slow_conversion_done;
   wire fast_irq, slow_irq;
   wire [15:0] fast_current_value, slow_current_value;
   wire [1:0] fast_settle, slow_settle;
   wire take;
   wire [`FCD_AW-3:0] rd_idx;
   wire [7:0] idx8;
   wire [7:0] rd8;
   reg [31:0] next_hrdata;
   assign take = hsel & hready & htrans[1];
   assign rd_idx = haddr[`FCD_AW-1:2];
   assign idx8 = wr_idx[7:0];
   assign rd8 = rd_idx[7:0];
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // two flops per detector pin
   wire [1:0] gate_pins;
   wire [1:0] gate_synced;
   assign gate_pins = {discharge_gate_high, charge_gate_high};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         reg [1:0] stages;
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               stages <= 2'h0;
            end else begin
               stages <= {stages[0], gate_pins[gi]};
            end
         end
         assign gate_synced[gi] = stages[1];
      end
   endgenerate
   // ------------------------------------------------------------
   // sub-blocks
   // ------------------------------------------------------------
   fcd_fet_check u_fet (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(fet_check_enable),
      .active_state(active_state),
      .fet_check_target(fet_check_target),
      .charge_gate_high(gate_synced[0]),
      .discharge_gate_high(gate_synced[1]),
      .pass_flags(pass_flags)
   );
   // ------------------------------------------------------------
   // write decode, data phase
   // ------------------------------------------------------------
   wire wr_stat;
   wire wr_adc_en;
   wire wr_diag_ctl;
   wire wr_switch;
   wire wr_cap_fast;
   wire wr_cap_slow;
   assign wr_stat = wr_pend && idx8 == `FCD_IDX_CTL_STAT;
   assign wr_adc_en = wr_pend && idx8 == `FCD_IDX_ADC_EN;
   assign wr_diag_ctl = wr_pend && idx8 == `FCD_IDX_DIAG_CTL;
   assign wr_switch = wr_pend && idx8 == `FCD_IDX_SWITCH;
   assign wr_cap_fast = wr_pend && idx8 == `FCD_IDX_CAP_FAST;
   assign wr_cap_slow = wr_pend && idx8 == `FCD_IDX_CAP_SLOW;
   // independent channels
   fcd_adc_path u_fast (
      .hclk(hclk),
      .hresetn(hresetn),
      .adc_on(fast_adc_on),
      .diag_req(fast_adc_selftest_enable),
      .done_clear(wr_stat & hwdata[`FCD_FAST_DONE]),
      .capture(fast_result_capture),
      .conv_done(fast_conv_done),
      .conv_value(fast_conv_value),
      .diag_mode(fast_diag_mode),
      .done_flag(fast_conversion_done),
      .done_irq(fast_irq),
      .result(fast_current_value),
      .settle_cnt(fast_settle)
   );
   fcd_adc_path u_slow (
      .hclk(hclk),
      .hresetn(hresetn),
      .adc_on(slow_adc_on),
      .diag_req(slow_adc_selftest_enable),
      .done_clear(wr_stat & hwdata[`FCD_SLOW_DONE]),
      .capture(slow_result_capture),
      .conv_done(slow_conv_done),
      .conv_value(slow_conv_value),
      .diag_mode(slow_diag_mode),
      .done_flag(slow_conversion_done),
      .done_irq(slow_irq),
      .result(slow_current_value),
      .settle_cnt(slow_settle)
   );
   // ------------------------------------------------------------
   // bus write tracking
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= {(`FCD_AW-2){1'b0}};
      end else begin
         wr_pend <= take & hwrite;
         if (take) begin
            wr_idx <= rd_idx;
         end
      end
   end
   // ------------------------------------------------------------
   // adc enables
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_adc_on <= 1'b0;
         slow_adc_on <= 1'b0;
      end else if (wr_adc_en) begin
         fast_adc_on <= hwdata[`FCD_FAST_ON];
         slow_adc_on <= hwdata[`FCD_SLOW_ON];
      end
   end
   // ------------------------------------------------------------
   // diagnostic control
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fet_check_enable <= 1'b0;
         fet_check_target <= `FCD_SEL_CHG_ON;
         fast_adc_selftest_enable <= 1'b0;
         slow_adc_selftest_enable <= 1'b0;
      end else if (wr_diag_ctl) begin
         fet_check_enable <= hwdata[`FCD_FET_EN];
         fet_check_target <= hwdata[`FCD_SEL_HI:`FCD_SEL_LO];
         fast_adc_selftest_enable <= hwdata[`FCD_FAST_DIAG];
         slow_adc_selftest_enable <= hwdata[`FCD_SLOW_DIAG];
      end
   end
   // ------------------------------------------------------------
   // operating mode and switch controls
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active_state <= 1'b0;
         charge_switch_control <= 1'b0;
         discharge_switch_control <= 1'b0;
      end else begin
         if (wr_stat) begin
            active_state <= hwdata[`FCD_ACTIVE];
         end
         if (wr_switch) begin
            charge_switch_control <= hwdata[`FCD_CHG_SW];
            discharge_switch_control <= hwdata[`FCD_DIS_SW];
         end
      end
   end
   // ------------------------------------------------------------
   // capture pulses
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_result_capture <= 1'b0;
         slow_result_capture <= 1'b0;
      end else begin
         // one-cycle pulse, reads back as zero
         fast_result_capture <= wr_cap_fast & hwdata[`FCD_FAST_CAP];
         slow_result_capture <= wr_cap_slow & hwdata[`FCD_SLOW_CAP];
      end
   end
   // ------------------------------------------------------------
   // read mux and outputs
   // ------------------------------------------------------------
   always @* begin
      next_hrdata = 32'h0000_0000;
      case (rd8)
         `FCD_IDX_ADC_EN: begin
            next_hrdata[`FCD_FAST_ON] = fast_adc_on;
            next_hrdata[`FCD_SLOW_ON] = slow_adc_on;
         end
         `FCD_IDX_DIAG_CTL: begin
            next_hrdata[`FCD_FET_EN] = fet_check_enable;
            next_hrdata[`FCD_SEL_HI:`FCD_SEL_LO] = fet_check_target;
            next_hrdata[`FCD_FAST_DIAG] = fast_adc_selftest_enable;
            next_hrdata[`FCD_SLOW_DIAG] = slow_adc_selftest_enable;
         end
         `FCD_IDX_CTL_STAT: begin
            next_hrdata[`FCD_ACTIVE] = active_state;
            next_hrdata[`FCD_FAST_DONE] = fast_conversion_done;
            next_hrdata[`FCD_SLOW_DONE] = slow_conversion_done;
            next_hrdata[`FCD_FSET_HI:`FCD_FSET_LO] = fast_settle;
            next_hrdata[`FCD_SSET_HI:`FCD_SSET_LO] = slow_settle;
         end
         `FCD_IDX_SWITCH: begin
            next_hrdata[`FCD_CHG_SW] = charge_switch_control;
            next_hrdata[`FCD_DIS_SW] = discharge_switch_control;
         end
         `FCD_IDX_DIAG_RES: next_hrdata[3:0] = pass_flags;
         `FCD_IDX_FAST_RES: next_hrdata[15:0] = fast_current_value;
         `FCD_IDX_SLOW_RES: next_hrdata[15:0] = slow_current_value;
         default: next_hrdata = 32'h0000_0000;
      endcase
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= `FCD_RESP_OKAY;
         fast_input_to_reference <= 1'b0;
         slow_input_to_reference <= 1'b0;
         fast_done_irq <= 1'b0;
         slow_done_irq <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= `FCD_RESP_OKAY;
         if (take && !hwrite) begin
            hrdata <= next_hrdata;
         end
         fast_input_to_reference <= fast_diag_mode;
         slow_input_to_reference <= slow_diag_mode;
         fast_done_irq <= fast_irq;
         slow_done_irq <= slow_irq;
      end
   end
endmodule // fcd_top

/* File: design/fcd_defs.vh */
// constants for the fet and current adc self-test block
// assumes a 32-bit ahb-lite slave with word registers
`ifndef FCD_DEFS_VH
`define FCD_DEFS_VH
// ------------------------------------------------------------
// register word index and address width
// ------------------------------------------------------------
`define FCD_IDX_ADC_EN 8'h18
`define FCD_IDX_DIAG_CTL 8'h1B
`define FCD_IDX_CTL_STAT 8'h1C
`define FCD_IDX_DIAG_RES 8'h21
`define FCD_IDX_SWITCH 8'h04
`define FCD_IDX_CAP_FAST 8'h0C
`define FCD_IDX_CAP_SLOW 8'h0A
`define FCD_IDX_FAST_RES 8'h47
`define FCD_IDX_SLOW_RES 8'h48
`define FCD_AW 10
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FCD_FAST_ON 0
`define FCD_SLOW_ON 1
`define FCD_FET_EN 10
`define FCD_SEL_HI 9
`define FCD_SEL_LO 8
`define FCD_FAST_DIAG 6
`define FCD_SLOW_DIAG 5
`define FCD_ACTIVE 0
`define FCD_FAST_DONE 6
`define FCD_SLOW_DONE 7
`define FCD_CHG_SW 10
`define FCD_DIS_SW 9
`define FCD_FAST_CAP 1
`define FCD_SLOW_CAP 2
`define FCD_FSET_HI 3
`define FCD_FSET_LO 2
`define FCD_SSET_HI 5
`define FCD_SSET_LO 4
// ------------------------------------------------------------
// check targets and values
// ------------------------------------------------------------
`define FCD_SEL_CHG_ON 2'h0
`define FCD_SEL_DIS_ON 2'h1
`define FCD_SEL_CHG_OFF 2'h2
`define FCD_SEL_DIS_OFF 2'h3
`define FCD_RESP_OKAY 2'h0
`define FCD_HTRANS_NONSEQ 2'h2
`define FCD_HSIZE_WORD 3'h2
// fixed diagnostic reference: 100 mV at 360 mV / 2^16 per step
`define FCD_REF_CODE 16'h4720
// completions from the request up to the first that carries the new mode
`define FCD_SWITCH_CNT 2'h2
`endif

/* File: design/fcd_fet_check.v */
// fet driver check: picks one pass flag per target
// assumes detector levels are already synchronous to hclk
`timescale 1ns/100ps
`include "fcd_defs.vh"
module fcd_fet_check (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // control
   input wire enable,
   input wire active_state,
   input wire [1:0] fet_check_target,
   // detector levels
   input wire charge_gate_high,
   input wire discharge_gate_high,
   // pass flags: charge_on, charge_off, discharge_on, discharge_off
   output reg [3:0] pass_flags
);
   wire run;
   assign run = enable & active_state;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pass_flags <= 4'h0;
      end else if (!run) begin
         pass_flags <= 4'h0;
      end else begin
         case (fet_check_target)
            `FCD_SEL_CHG_ON: pass_flags[3] <= charge_gate_high;
            `FCD_SEL_CHG_OFF: pass_flags[2] <= ~charge_gate_high;
            `FCD_SEL_DIS_ON: pass_flags[1] <= discharge_gate_high;
            default: pass_flags[0] <= ~discharge_gate_high;
         endcase
      end
   end
endmodule // fcd_fet_check

/* File: design/fcd_adc_path.v */
// one current adc channel: diag switch, done flag, irq, capture
// assumes conv_done is a one-cycle pulse on hclk
`timescale 1ns/100ps
`include "fcd_defs.vh"
module fcd_adc_path (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // control
   input wire adc_on,
   input wire diag_req,
   input wire done_clear,
   input wire capture,
   // converter
   input wire conv_done,
   input wire [15:0] conv_value,
   // status
   output reg diag_mode,
   output reg done_flag,
   output reg done_irq,
   output reg [15:0] result,
   output reg [1:0] settle_cnt
);
   reg [15:0] held;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         diag_mode <= 1'b0;
         done_flag <= 1'b0;
         done_irq <= 1'b0;
         result <= 16'h0000;
         held <= 16'h0000;
         settle_cnt <= 2'h0;
      end else begin
         // input switches at a slot boundary, or at once while the adc is off
         if (diag_req != diag_mode && (conv_done || !adc_on)) begin
            diag_mode <= diag_req;
         end
         // completions left until data matches the mode
         if (diag_req != diag_mode && conv_done) begin
            settle_cnt <= `FCD_SWITCH_CNT - 2'h1;
         end else if (conv_done && settle_cnt != 2'h0) begin
            settle_cnt <= settle_cnt - 2'h1;
         end
         if (conv_done) begin
            held <= diag_mode ? `FCD_REF_CODE : conv_value;
         end
         done_flag <= conv_done | (done_flag & ~done_clear);
         if (conv_done) begin
            done_irq <= 1'b1;
         end else if (capture) begin
            done_irq <= 1'b0;
         end
         if (capture) begin
            result <= held;
         end
      end
   end
endmodule // fcd_adc_path

/* File: dv/fcd_monitor.sv */
// port checker for fcd_top
// assumes one ahb-lite master and hready tied to hreadyout
`timescale 1ns/100ps
`include "fcd_defs.vh"
module fcd_monitor (
   // clock, reset, bus
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [`FCD_AW-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hwdata,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire [1:0] hresp,
   // converter and control side
   input wire fast_conv_done,
   input wire slow_conv_done,
   input wire fast_adc_on,
   input wire slow_adc_on,
   input wire fast_input_to_reference,
   input wire charge_switch_control,
   input wire fast_done_irq,
   input wire slow_done_irq
);
// --------------------
// data phase tracking
// --------------------
reg wr_ph;
reg rd_ph;
reg [7:0] idx;
reg fet_en;
wire take = hsel & hready & htrans[1];
wire cap_f = wr_ph & (idx == `FCD_IDX_CAP_FAST) & hwdata[`FCD_FAST_CAP];
wire cap_s = wr_ph & (idx == `FCD_IDX_CAP_SLOW) & hwdata[`FCD_SLOW_CAP];
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
      idx <= 8'h00;
      fet_en <= 1'b0;
   end else begin
      wr_ph <= take & hwrite;
      rd_ph <= take & ~hwrite;
      idx <= haddr[9:2];
      if (wr_ph && idx == `FCD_IDX_DIAG_CTL)
         fet_en <= hwdata[`FCD_FET_EN];
   end
end
default clocking dc @(posedge hclk); endclocking
default disable iff (!hresetn);
// --------------------
// assertions
// --------------------
zero_wait_a: assert property (hreadyout)
   else $error("wait state inserted");
resp_okay_a: assert property (hresp == `FCD_RESP_OKAY)
   else $error("response not okay");
fast_irq_rise_a: assert property (fast_conv_done |-> ##2 fast_done_irq)
   else $error("fast irq not raised");
slow_irq_rise_a: assert property (slow_conv_done |-> ##2 slow_done_irq)
   else $error("slow irq not raised");
fast_irq_drop_a: assert property (cap_f |-> ##[1:4] !fast_done_irq)
   else $error("fast irq not dropped");
slow_irq_drop_a: assert property (cap_s |-> ##[1:4] !slow_done_irq)
   else $error("slow irq not dropped");
adc_on_write_a: assert property (wr_ph && idx == `FCD_IDX_ADC_EN |=>
   {slow_adc_on, fast_adc_on} == $past(hwdata[1:0]))
   else $error("adc enables wrong");
switch_write_a: assert property (wr_ph && idx == `FCD_IDX_SWITCH |=>
   charge_switch_control == $past(hwdata[`FCD_CHG_SW]))
   else $error("switch control wrong");
pass_zero_a: assert property (rd_ph && idx == `FCD_IDX_DIAG_RES && !fet_en
   |-> hrdata[3:0] == 4'h0)
   else $error("pass bits set while off");
ref_switch_a: assert property ($rose(fast_input_to_reference) |->
   $past(fast_conv_done) || $past(fast_conv_done, 2) || !fast_adc_on)
   else $error("reference switched mid slot");
cover property ($rose(fast_done_irq));
cover property ($rose(fast_input_to_reference));
cover property (cap_s);
endmodule // fcd_monitor
bind fcd_top fcd_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .fast_conv_done(fast_conv_done), .slow_conv_done(slow_conv_done),
   .fast_adc_on(fast_adc_on), .slow_adc_on(slow_adc_on),
   .fast_input_to_reference(fast_input_to_reference),
   .charge_switch_control(charge_switch_control),
   .fast_done_irq(fast_done_irq), .slow_done_irq(slow_done_irq));

/* File: dv/fcd_analog_model.sv */
// converters and gate detectors seen by fcd_top
// assumes done pulses last one hclk cycle
`timescale 1ns/100ps
module fcd_analog_model #(
   parameter FAST_PER = 50,
   parameter SLOW_PER = 70
) (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // from the block and the bench
   input wire fast_adc_on,
   input wire slow_adc_on,
   input wire charge_switch_control,
   input wire discharge_switch_control,
   input wire gate_fault,
   input wire [15:0] fast_sense,
   input wire [15:0] slow_sense,
   // to the block
   output reg fast_conv_done,
   output reg [15:0] fast_conv_value,
   output reg slow_conv_done,
   output reg [15:0] slow_conv_value,
   output wire charge_gate_high,
   output wire discharge_gate_high
);
integer fc;
integer sc;
assign charge_gate_high = charge_switch_control ^ gate_fault;
assign discharge_gate_high = discharge_switch_control ^ gate_fault;
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      fc <= 0;
      sc <= 0;
      fast_conv_done <= 1'b0;
      slow_conv_done <= 1'b0;
   end else begin
      fc <= (fast_adc_on && fc < FAST_PER - 1) ? fc + 1 : 0;
      sc <= (slow_adc_on && sc < SLOW_PER - 1) ? sc + 1 : 0;
      fast_conv_done <= fast_adc_on && fc == FAST_PER - 1;
      slow_conv_done <= slow_adc_on && sc == SLOW_PER - 1;
   end
end
// value is only good with the pulse
always @* begin
   fast_conv_value = fast_conv_done ? fast_sense : ~fast_sense;
   slow_conv_value = slow_conv_done ? slow_sense : ~slow_sense;
end
endmodule // fcd_analog_model

/* File: dv/fet_and_current_adc_diagnostics_tb.sv */
// self-checking bench for fcd_top
// assumes fcd_monitor and fcd_analog_model compiled first
`timescale 1ns/100ps
`include "fcd_defs.vh"
module fet_and_current_adc_diagnostics_tb;
reg hclk = 1'b0;
reg hresetn = 1'b0;
reg hsel = 1'b0;
reg [9:0] haddr = 10'h000;
reg [1:0] htrans = 2'h0;
reg hwrite = 1'b0;
reg [2:0] hsize = 3'h2;
reg [31:0] hwdata = 32'h0;
reg fault = 1'b0;
reg [15:0] fsense = 16'h0;
reg [15:0] ssense = 16'h0;
wire [31:0] hrdata;
wire hreadyout;
wire [1:0] hresp;
wire fdone, sdone, cg, dg, fon, son, fref, sref, csw, dsw, firq, sirq;
wire [15:0] fval;
wire [15:0] sval;
integer err_total = 0;
integer num_checks = 0;
integer seed = 32'hF466;
integer cyc = 0;
integer t, k, ch;
reg [31:0] d;
reg [1:0] sel;
reg act, f;
always #2 hclk = ~hclk;
fcd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
   .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .charge_gate_high(cg), .discharge_gate_high(dg),
   .fast_conv_done(fdone), .fast_conv_value(fval),
   .slow_conv_done(sdone), .slow_conv_value(sval),
   .fast_adc_on(fon), .slow_adc_on(son), .fast_input_to_reference(fref),
   .slow_input_to_reference(sref), .charge_switch_control(csw),
   .discharge_switch_control(dsw), .fast_done_irq(firq),
   .slow_done_irq(sirq));
fcd_analog_model model (.hclk(hclk), .hresetn(hresetn), .fast_adc_on(fon),
   .slow_adc_on(son), .charge_switch_control(csw),
   .discharge_switch_control(dsw), .gate_fault(fault), .fast_sense(fsense),
   .slow_sense(ssense), .fast_conv_done(fdone), .fast_conv_value(fval),
   .slow_conv_done(sdone), .slow_conv_value(sval),
   .charge_gate_high(cg), .discharge_gate_high(dg));
// --------------------
// tasks and functions
// --------------------
task chk(input [31:0] got, input [31:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   end
endtask
task close_out;
   begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
endtask
task xfer(input w, input [7:0] idx, input [31:0] wd, output [31:0] rd);
   begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {idx, 2'b00};
      htrans <= `FCD_HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= `FCD_HSIZE_WORD;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   end
endtask
task take(input integer c, output [31:0] r);
   begin
      while ((c ? sirq : firq) !== 1'b1) @(posedge hclk);
      xfer(1'b0, `FCD_IDX_CTL_STAT, 32'h0, r);
      chk({31'h0, r[c ? 7 : 6]}, 32'h1);
      xfer(1'b1, `FCD_IDX_CTL_STAT, c ? 32'h80 : 32'h40, r);
      xfer(1'b0, `FCD_IDX_CTL_STAT, 32'h0, r);
      chk({31'h0, r[c ? 7 : 6]}, 32'h0);
      xfer(1'b1, c ? `FCD_IDX_CAP_SLOW : `FCD_IDX_CAP_FAST,
         c ? 32'h4 : 32'h2, r);
      xfer(1'b0, c ? `FCD_IDX_SLOW_RES : `FCD_IDX_FAST_RES, 32'h0, r);
   end
endtask
function [3:0] exp_flags(input [1:0] s, input a, input g);
   reg on;
   begin
      on = ~s[1];
      exp_flags = 4'h0;
      if (a && ((on ^ g) == on))
         exp_flags[s == 2'h0 ? 3 : s == 2'h1 ? 1 : s == 2'h2 ? 2 : 0] = 1'b1;
   end
endfunction
function in_band(input [15:0] v);
   integer m;
   begin
      m = $signed(v) * 360;
      in_band = (m >= 90 * 65536) && (m <= 110 * 65536);
   end
endfunction
always @(posedge hclk) begin
   cyc <= cyc + 1;
   if (cyc == 20000) begin
      err_total = err_total + 1;
      close_out;
   end
end
// --------------------
// main sequence
// --------------------
initial begin
   repeat (20) @(posedge hclk);
   hresetn <= 1'b1;
   xfer(1'b0, `FCD_IDX_ADC_EN, 32'h0, d);
   chk({30'h0, d[1:0]}, 32'h0);
   xfer(1'b1, 8'hFF, 32'hFFFFFFFF, d);
   xfer(1'b0, 8'hFF, 32'h0, d);
   chk(d, 32'h0);
   $display("test reset_map done");
   for (t = 0; t < 12; t = t + 1) begin
      sel = t[1:0];
      act = (t < 8);
      f = (t >= 4) && (t < 8) && $random(seed);
      fault <= f;
      xfer(1'b1, `FCD_IDX_SWITCH, sel[1] ? 32'h0 : 32'h600, d);
      xfer(1'b1, `FCD_IDX_CTL_STAT, {31'h0, act}, d);
      xfer(1'b1, `FCD_IDX_DIAG_CTL, {22'h0, sel, 8'h00}, d);
      xfer(1'b1, `FCD_IDX_DIAG_CTL, {21'h0, 1'b1, sel, 8'h00}, d);
      repeat (10) @(posedge hclk);
      xfer(1'b0, `FCD_IDX_DIAG_RES, 32'h0, d);
      chk(d[3:0] & exp_flags(sel, 1'b1, 1'b0), exp_flags(sel, act, f));
      xfer(1'b1, `FCD_IDX_DIAG_CTL, {22'h0, sel, 8'h00}, d);
      xfer(1'b0, `FCD_IDX_DIAG_RES, 32'h0, d);
      chk({28'h0, d[3:0]}, 32'h0);
   end
   $display("test fet_check done");
   fsense <= $random(seed);
   ssense <= $random(seed);
   xfer(1'b1, `FCD_IDX_ADC_EN, 32'h3, d);
   @(posedge hclk);
   chk({30'h0, son, fon}, 32'h3);
   for (ch = 0; ch < 2; ch = ch + 1) begin
      take(ch, d);
      xfer(1'b1, `FCD_IDX_DIAG_CTL, ch ? 32'h20 : 32'h40, d);
      for (k = 1; k < 7; k = k + 1) begin
         if (k == 5)
            xfer(1'b1, `FCD_IDX_DIAG_CTL, 32'h0, d);
         take(ch, d);
         chk({16'h0, d[15:0]}, (k == 1 || k == 6) ? (ch ? ssense : fsense)
            : `FCD_REF_CODE);
         if (k == 3) begin
            chk({31'h0, in_band(d[15:0])}, 32'h1);
            chk({31'h0, ch ? sref : fref}, 32'h1);
            chk({31'h0, ch ? fref : sref}, 32'h0);
            take(1 - ch, d);
            chk({16'h0, d[15:0]}, ch ? fsense : ssense);
         end
      end
      $display("test adc_diag channel %0d done", ch);
   end
   close_out;
end
endmodule // fet_and_current_adc_diagnostics_tb
